// File: logic/line_interface_config_control.sv
// configuration register and its mode decode, loopback mux and one-second status latching
// assumes a microprocessor port with one-cycle read and write strobes, synchronous inputs
`timescale 1ns/1ps
`default_nettype none
`include "line_if_cfg.svh"

module status_latch
	import line_if_pkg::*;
(
	// clock and reset
	input  wire logic        clock,
	input  wire logic        srst,
	// control
	input  wire logic        latch_en,
	input  wire logic        tick,
	input  wire logic        rd,
	// status
	input  wire logic [15:0] live,
	output logic      [15:0] shown
);
	latch_state_t s_q;
	latch_state_t s_d;

	always_comb begin
		s_d = s_q;
		if (!latch_en) begin
			// sticky until read; a new alarm in the read cycle survives
			s_d.acc       = '0;
			s_d.read_once = 1'b0;
			s_d.held      = rd ? live : (s_q.held | live);
		end else if (tick) begin
			s_d.held      = s_q.acc | live;
			s_d.acc       = '0;
			s_d.read_once = 1'b0;
		end else begin
			s_d.acc = s_q.acc | live;
			if (rd) begin
				s_d.read_once = 1'b1;
				if (s_q.read_once) begin
					s_d.held = '0;
				end
			end
		end
	end

	assign shown = (latch_en && s_q.read_once) ? live : s_q.held;

	always_ff @(posedge clock) begin
		if (srst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (srst);

	tick_hold_a: assert property (latch_en && tick |=> s_q.held == $past(s_q.acc | live))
		else $error("interval tick did not transfer accumulated alarms");
	second_read_a: assert property (latch_en && !tick && rd && s_q.read_once |=> s_q.held == '0)
		else $error("second read in interval did not clear status");

	// without latching no alarm may be lost, whether or not a read lands on it
	sticky_keep_a: assert property (!latch_en |=> (s_q.held & $past(live)) == $past(live))
		else $error("unlatched alarm dropped");
	off_clear_a: assert property (!latch_en |=> !s_q.read_once && s_q.acc == '0)
		else $error("interval state left over while latching is off");
	acc_collect_a: assert property (latch_en && !tick |=> (s_q.acc & $past(live)) == $past(live))
		else $error("alarm not collected during interval");
	tick_rearm_a: assert property (latch_en && tick |=> !s_q.read_once && s_q.acc == '0)
		else $error("interval boundary did not restart collection");
	read_mark_a: assert property (latch_en && !tick && rd |=> s_q.read_once)
		else $error("read within interval not remembered");
	first_read_a: assert property (latch_en && !s_q.read_once |-> shown == s_q.held)
		else $error("first read did not show latched status");
	later_read_a: assert property (latch_en && s_q.read_once |-> shown == live)
		else $error("later read did not show current status");
endmodule : status_latch

module line_interface_config_control
	import line_if_pkg::*;
#(
	parameter int STAT_W = 16
) (
	// clock and reset
	input  wire logic        clock,
	input  wire logic        srst,
	// microprocessor register port, word index a[7:1]
	input  wire logic        cs,
	input  wire logic        wr_en,
	input  wire logic        rd_en,
	input  wire logic [6:0]  addr,
	input  wire logic [15:0] wdata,
	output logic      [15:0] rdata,
	// timing references
	input  wire logic        one_second_reference_input,
	input  wire logic        transmit_sync_input,
	input  wire logic        ext_8k_reference,
	input  wire logic        rx_frame_reference,
	// line side
	input  wire logic [7:0]  tx_line_data,
	input  wire logic [7:0]  rx_line_data,
	input  wire logic        rx_line_sync,
	output line_word_t       rx_feed,
	output logic             payload_valid,
	// receive cell path
	input  wire logic        receive_hold_input,
	input  wire logic        loss_of_cell_delineation,
	output logic             cell_accept,
	output logic             fifo_out_enable,
	// decoded modes
	output physical_framing_type_field_t        physical_framing_type_field,
	output logic [6:0]       payload_columns,
	output logic [5:0]       cell_length,
	output logic             hec_delineation,
	output logic             parallel_mode,
	output logic             external_framer,
	output logic             coder_bypass,
	output logic             unframed_mode,
	output logic             scrambler_enable,
	output logic             tx_frame_sync,
	// status latching
	input  wire logic [15:0] line_status_live,
	input  wire logic [15:0] counter_status_live,
	input  wire logic        line_status_rd,
	input  wire logic        counter_status_rd,
	output logic      [15:0] line_status_out,
	output logic      [15:0] counter_status_out
);
	top_state_t  s_q;
	top_state_t  s_d;
	logic        onesec_tick;
	logic        loop_active;
	logic        use_ext_8k;
	logic        hold_now;
	logic [15:0] line_shown;
	logic [15:0] cnt_shown;

	// third stage only feeds the edge detector, the first stage feeds nothing else
	assign onesec_tick = s_q.onesec_sync[1] && !s_q.onesec_sync[2];

	// no loopback path exists in parallel cell mode
	assign loop_active = s_q.cfg[`BIT_LOOP] && !s_q.cfg[`BIT_PARALLEL];

	assign use_ext_8k = s_q.cfg[`BIT_EXT_8K] && !s_q.cfg[`BIT_HEC] &&
		(s_q.cfg[2:0] == `PHY_DS3 || s_q.cfg[2:0] == `PHY_E3_PLCP);

	assign hold_now = s_q.cfg[`BIT_HOLD_EN] && receive_hold_input;

	// the counter group carries no code-violation count; that count bypasses latching
	status_latch u_line_latch (
		.clock    (clock),
		.srst     (srst),
		.latch_en (s_q.cfg[`BIT_LATCH_STAT]),
		.tick     (onesec_tick),
		.rd       (line_status_rd),
		.live     (line_status_live),
		.shown    (line_shown)
	);

	status_latch u_cnt_latch (
		.clock    (clock),
		.srst     (srst),
		.latch_en (s_q.cfg[`BIT_LATCH_CNT]),
		.tick     (onesec_tick),
		.rd       (counter_status_rd),
		.live     (counter_status_live),
		.shown    (cnt_shown)
	);

	always_comb begin
		s_d = s_q;
		s_d.onesec_sync = {s_q.onesec_sync[1:0], one_second_reference_input};
		if (cs && wr_en && addr == `CFG_ADDR) begin
			s_d.cfg = wdata;
		end
		s_d.rdata = '0;
		if (cs && rd_en && addr == `CFG_ADDR) begin
			s_d.rdata = s_q.cfg;
		end
		// in loopback the external framer still owns the sync input
		if (loop_active) begin
			s_d.rx_feed.data = tx_line_data;
			s_d.rx_feed.sync = transmit_sync_input;
		end else begin
			s_d.rx_feed.data = rx_line_data;
			s_d.rx_feed.sync = rx_line_sync;
		end
		// framed mode treats sync-marked positions as overhead to skip
		s_d.payload_valid = s_q.cfg[`BIT_UNFRAMED] || !s_d.rx_feed.sync;
		s_d.cell_accept = !hold_now &&
			(s_q.cfg[`BIT_NO_LOSS_OF_CELL_DELINEATION] || !loss_of_cell_delineation);
		s_d.fifo_out_enable = !hold_now;
		if (line_status_rd) begin
			s_d.line_status_out = line_shown;
		end
		if (counter_status_rd) begin
			s_d.counter_status_out = cnt_shown;
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			// configuration survives reset, software must program it
			s_q.onesec_sync        <= '0;
			s_q.rdata              <= '0;
			s_q.rx_feed            <= '0;
			s_q.payload_valid      <= 1'b0;
			s_q.cell_accept        <= 1'b0;
			s_q.fifo_out_enable    <= 1'b0;
			s_q.line_status_out    <= '0;
			s_q.counter_status_out <= '0;
			s_q.cfg                <= s_d.cfg;
		end else begin
			s_q <= s_d;
		end
	end

	assign rdata              = s_q.rdata;
	assign rx_feed            = s_q.rx_feed;
	assign payload_valid      = s_q.payload_valid;
	assign cell_accept        = s_q.cell_accept;
	assign fifo_out_enable    = s_q.fifo_out_enable;
	assign line_status_out    = s_q.line_status_out;
	assign counter_status_out = s_q.counter_status_out;

	// mode decode; type codes are the same for both directions
	assign physical_framing_type_field = s_q.cfg[2:0];
	assign payload_columns = (s_q.cfg[`BIT_STUFF] && s_q.cfg[2:0] == `PHY_STS1) ?
		`COLS_STUFFED : `COLS_FULL;
	assign cell_length      = s_q.cfg[`BIT_HEC] ? `CELL_LEN_HEC : `CELL_LEN_PLCP;
	assign hec_delineation  = s_q.cfg[`BIT_HEC];
	assign parallel_mode    = s_q.cfg[`BIT_PARALLEL];
	assign external_framer  = s_q.cfg[`BIT_EXT_FRAMER];
	// software keeps this clear for E1 and DS1 behind an external framer
	assign coder_bypass     = s_q.cfg[`BIT_NO_CODER];
	assign unframed_mode    = s_q.cfg[`BIT_UNFRAMED];
	assign scrambler_enable = s_q.cfg[`BIT_SCRAMBLE];
	assign tx_frame_sync    = use_ext_8k ? ext_8k_reference : rx_frame_reference;

	default clocking cb @(posedge clock); endclocking
	default disable iff (srst);

	cfg_write_a: assert property (cs && wr_en && addr == `CFG_ADDR |=> s_q.cfg == $past(wdata))
		else $error("configuration write not stored");
	cfg_read_a: assert property (cs && rd_en && addr == `CFG_ADDR && !wr_en |=> rdata == s_q.cfg)
		else $error("configuration read returned wrong data");
	stuff_cols_a: assert property (payload_columns == ((s_q.cfg[15] && s_q.cfg[2:0] == 3'h6)
		? 7'h54 : 7'h56))
		else $error("payload column count wrong");
	loop_feed_a: assert property (s_q.cfg[14] && !s_q.cfg[6] && !$changed(s_q.cfg)
		|=> rx_feed.data == $past(tx_line_data))
		else $error("loopback did not feed receiver from transmitter");
	no_loop_par_a: assert property (s_q.cfg[6] && !$changed(s_q.cfg)
		|=> rx_feed.data == $past(rx_line_data))
		else $error("loopback active in parallel mode");
	hold_block_a: assert property (s_q.cfg[10] && receive_hold_input
		|=> !cell_accept && !fifo_out_enable)
		else $error("receive hold did not block cells");
	loss_of_cell_delineation_gate_a: assert property (!s_q.cfg[10] && !s_q.cfg[8] && loss_of_cell_delineation
		|=> !cell_accept)
		else $error("cells accepted after delineation loss");
	cell_len_a: assert property (cell_length == (s_q.cfg[7] ? 6'h35 : 6'h39))
		else $error("cell length does not follow delineation mode");
	ext_8k_a: assert property (s_q.cfg[7] |-> tx_frame_sync == rx_frame_reference)
		else $error("external timing used outside 57-octet modes");
	framed_skip_a: assert property (!s_q.cfg[3] && $past(!s_q.cfg[3]) && rx_feed.sync
		|-> !payload_valid)
		else $error("overhead position marked as payload");
	onesec_edge_a: assert property ($rose(s_q.onesec_sync[1]) |-> onesec_tick)
		else $error("one-second edge missed");
	tick_one_a: assert property (onesec_tick |=> !onesec_tick)
		else $error("interval boundary longer than one cycle");

	// plain mode bits must mirror the register exactly
	scr_bit_a: assert property (scrambler_enable == s_q.cfg[9])
		else $error("scrambler enable does not follow register");
	par_bit_a: assert property (parallel_mode == s_q.cfg[6])
		else $error("parallel select does not follow register");
	framer_bit_a: assert property (external_framer == s_q.cfg[5])
		else $error("framer select does not follow register");
	coder_bit_a: assert property (coder_bypass == s_q.cfg[4])
		else $error("coder bypass does not follow register");
	hec_bit_a: assert property (hec_delineation == s_q.cfg[7])
		else $error("delineation select does not follow register");
	unfr_bit_a: assert property (unframed_mode == s_q.cfg[3])
		else $error("unframed select does not follow register");
	phy_field_a: assert property (physical_framing_type_field == s_q.cfg[2:0])
		else $error("framing type does not follow register");
	cfg_hold_a: assert property (!(cs && wr_en && addr == `CFG_ADDR) |=> $stable(s_q.cfg))
		else $error("configuration changed without a write");
	rdata_idle_a: assert property (!(cs && rd_en && addr == `CFG_ADDR) |=> rdata == '0)
		else $error("read data present without a read");

	// external timing is only honoured for the 57-octet DS3 and E3 types
	ext_8k_on_a: assert property (s_q.cfg[11] && !s_q.cfg[7] &&
		(s_q.cfg[2:0] == `PHY_DS3 || s_q.cfg[2:0] == `PHY_E3_PLCP)
		|-> tx_frame_sync == ext_8k_reference)
		else $error("external timing not used");
	loop_sync_a: assert property (s_q.cfg[14] && !s_q.cfg[6] && !$changed(s_q.cfg)
		|=> rx_feed.sync == $past(transmit_sync_input))
		else $error("looped path lost its sync marker");
	unfr_valid_a: assert property (s_q.cfg[3] |=> payload_valid)
		else $error("unframed stream marked as overhead");
	fifo_free_a: assert property (!s_q.cfg[10] |=> fifo_out_enable)
		else $error("fifo output blocked without hold enable");
	loss_of_cell_delineation_pass_a: assert property (!s_q.cfg[10] && s_q.cfg[8] |=> cell_accept)
		else $error("cells refused although delineation loss is ignored");

	// status words are captured on the read pulse and held until the next one
	line_cap_a: assert property (line_status_rd |=> line_status_out == $past(line_shown))
		else $error("line status read not captured");
	line_keep_a: assert property (!line_status_rd |=> $stable(line_status_out))
		else $error("line status changed without a read");
	cnt_cap_a: assert property (counter_status_rd |=> counter_status_out == $past(cnt_shown))
		else $error("counter status read not captured");
	cnt_keep_a: assert property (!counter_status_rd |=> $stable(counter_status_out))
		else $error("counter status changed without a read");
endmodule : line_interface_config_control
`default_nettype wire

// File: include/line_if_cfg.svh
// constants of the line interface configuration block
// assumes a 16-bit register port addressed by word index a[7:1]
//
// Overview of operation
// - stuffing bit set gives 84 cell columns in the STS-1 envelope, else 86.
// - source loopback feeds receiver from transmitter output; transmitter output unchanged.
// - no loopback path while the parallel cell interface is selected.
// - bit 13 latches counter status, except code violations, per one-second interval.
// - bit 12 latches line status once per one-second interval.
// - alarm in one interval is readable in the next; else held until read.
// - a second read within one interval returns current status and clears it.
// - bit 11 syncs transmit framing to external 8 kHz, only 57-octet DS3/E3.
// - bit 10 with hold input blocks cell acceptance and FIFO output.
// - bit 9 enables the x^43+1 payload scrambler.
// - bit 8 keeps validation and error counting alive after delineation loss.
// - bit 7 selects header-check delineation with 53-octet cells, else 57-octet.
// - bit 6 low selects serial line path, high selects parallel both ways.
// - bit 5 selects the external framer, else the internal one.
// - bit 4 bypasses line coder; keep clear for E1/DS1 with external framer.
// - bit 3 clear skips sync-marked overhead bits; set means payload only.
// - bits 2-0 pick the framing type, same for transmit and receive.
// - type codes 0 DS1,1 E1,2 DS3,3 E3 old,4 E3 direct,5 E4,6 STS-1,7 STS-3c.
// - reset clears counters and state but not the configuration register.
`ifndef LINE_IF_CFG_SVH
`define LINE_IF_CFG_SVH
`define CFG_ADDR       7'h00
`define BIT_STUFF      15
`define BIT_LOOP       14
`define BIT_LATCH_CNT  13
`define BIT_LATCH_STAT 12
`define BIT_EXT_8K     11
`define BIT_HOLD_EN    10
`define BIT_SCRAMBLE   9
`define BIT_NO_LOSS_OF_CELL_DELINEATION    8
`define BIT_HEC        7
`define BIT_PARALLEL   6
`define BIT_EXT_FRAMER 5
`define BIT_NO_CODER   4
`define BIT_UNFRAMED   3
`define COLS_STUFFED   7'h54
`define COLS_FULL      7'h56
`define CELL_LEN_HEC   6'h35
`define CELL_LEN_PLCP  6'h39
`define PHY_DS1        3'h0
`define PHY_E1         3'h1
`define PHY_DS3        3'h2
`define PHY_E3_PLCP    3'h3
`define PHY_E3_DIRECT  3'h4
`define PHY_E4         3'h5
`define PHY_STS1       3'h6
`define PHY_STS3C      3'h7
`endif

// File: include/line_if_pkg.sv
// types shared by the line interface configuration block
// assumes the constants header is included alongside
package line_if_pkg;
	typedef logic [2:0] physical_framing_type_field_t;
	typedef struct packed {
		logic [7:0] data;
		logic       sync;
	} line_word_t;
	typedef struct packed {
		logic [15:0] acc;
		logic [15:0] held;
		logic        read_once;
	} latch_state_t;
	typedef struct packed {
		logic [15:0] cfg;
		logic [2:0]  onesec_sync;
		logic [15:0] rdata;
		line_word_t  rx_feed;
		logic        payload_valid;
		logic        cell_accept;
		logic        fifo_out_enable;
		logic [15:0] line_status_out;
		logic [15:0] counter_status_out;
	} top_state_t;
endpackage : line_if_pkg

// File: test/line_partner.sv
// receive side model of the line interface or external framer
// assumes the bench clock; the word changes every cycle so stale data shows
`timescale 1ns/1ps
`default_nettype none
module line_partner (
	// clock and reset
	input  wire logic       clock,
	input  wire logic       srst,
	// line receive side
	output logic      [7:0] rx_line_data,
	output logic            rx_line_sync,
	// framer sync toward the transmitter
	output logic            transmit_sync_input
);
	logic [7:0] cnt_q = 8'h00;
	always @(posedge clock) begin
		cnt_q <= srst ? 8'h00 : cnt_q + 8'h01;
	end
	// sync keeps running in loopback too, so the looped path stays framed
	assign transmit_sync_input = (cnt_q[2:0] == 3'h5);
	assign rx_line_data        = cnt_q ^ 8'ha5;
	assign rx_line_sync        = (cnt_q[2:0] == 3'h0);
endmodule : line_partner
`default_nettype wire

// File: test/tb.sv
// bench of the configuration register: decode, loop path, cell gating, latching
// assumes line_partner on the receive side and one-cycle register strobes
`timescale 1ns/1ps
`default_nettype none
module tb
	import line_if_pkg::*;
();
	logic       clock = 1'b0, srst = 1'b1, cs = 1'b0, wr_en = 1'b0, rd_en = 1'b0;
	logic       one_second_reference_input = 1'b0, ext_8k_reference = 1'b0;
	logic       rx_frame_reference = 1'b0, receive_hold_input = 1'b0;
	logic       loss_of_cell_delineation = 1'b0, line_status_rd = 1'b0;
	logic       counter_status_rd = 1'b0;
	logic [6:0] addr = 7'h00;
	logic [15:0] wdata = 16'h0000, line_status_live = 16'h0000;
	logic [15:0] counter_status_live = 16'h0000;
	logic [7:0] tx_line_data = 8'h00, rx_line_data;
	logic       rx_line_sync, transmit_sync_input, payload_valid, cell_accept;
	logic       fifo_out_enable, hec, par, ext, cod, unf, scr, tfs, pv;
	logic [15:0] rdata, lso, cso, v, d, c, sa, sb, sc;
	logic [15:0] pcfg [5] = '{16'h4002, 16'h40e0, 16'h052a, 16'h0402, 16'h0102};
	logic [6:0] cols;
	logic [5:0] clen;
	logic [1:0] eg;
	physical_framing_type_field_t  phy;
	line_word_t rx_feed, ef;
	int         fail_count = 0, checks_done = 0;

	line_interface_config_control dut (
		.clock, .srst, .cs, .wr_en, .rd_en, .addr, .wdata, .rdata,
		.one_second_reference_input, .transmit_sync_input, .ext_8k_reference,
		.rx_frame_reference, .tx_line_data, .rx_line_data, .rx_line_sync, .rx_feed,
		.payload_valid, .receive_hold_input, .loss_of_cell_delineation, .cell_accept,
		.fifo_out_enable, .physical_framing_type_field(phy), .payload_columns(cols),
		.cell_length(clen), .hec_delineation(hec), .parallel_mode(par),
		.external_framer(ext), .coder_bypass(cod), .unframed_mode(unf),
		.scrambler_enable(scr), .tx_frame_sync(tfs), .line_status_live,
		.counter_status_live, .line_status_rd, .counter_status_rd,
		.line_status_out(lso), .counter_status_out(cso)
	);
	line_partner far (.clock, .srst, .rx_line_data, .rx_line_sync, .transmit_sync_input);

	always #2.5 clock = ~clock;

	task automatic chk(string n, logic [15:0] e, logic [15:0] s);
		checks_done++;
		if (s !== e) begin
			fail_count++;
			$display("FAIL %s expected %h seen %h", n, e, s);
		end
	endtask : chk

	task automatic wr(logic [6:0] a, logic [15:0] dv);
		@(posedge clock);
		cs <= 1'b1;
		wr_en <= 1'b1;
		addr <= a;
		wdata <= dv;
		@(posedge clock);
		cs <= 1'b0;
		wr_en <= 1'b0;
		#1;
	endtask : wr

	task automatic rd(logic [6:0] a, output logic [15:0] dv);
		@(posedge clock);
		cs <= 1'b1;
		rd_en <= 1'b1;
		addr <= a;
		@(posedge clock);
		cs <= 1'b0;
		rd_en <= 1'b0;
		#1 dv = rdata;
	endtask : rd

	task automatic srd(logic grp, output logic [15:0] dv);
		@(posedge clock);
		counter_status_rd <= grp;
		line_status_rd <= !grp;
		@(posedge clock);
		counter_status_rd <= 1'b0;
		line_status_rd <= 1'b0;
		#1 dv = grp ? cso : lso;
	endtask : srd

	// software only writes valid low bytes, one per framing type
	function automatic logic [7:0] lowb(int t);
		logic [7:0] tbl [8] = '{8'h20, 8'h21, 8'h02, 8'h03, 8'h84, 8'h95, 8'h86, 8'h97};
		return tbl[t];
	endfunction : lowb

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : report_and_stop

	initial begin
		void'($urandom(32'hc6d4));
		// the register survives reset, so give it a known value while reset is held
		repeat (8) @(posedge clock);
		wr(7'h00, 16'h0000);
		srst <= 1'b0;
		for (int t = 0; t < 8; t++) begin
			v = 16'($urandom);
			v[7:0] = lowb(t);
			v[11] = v[11] | (t == 2);
			ext_8k_reference <= 1'($urandom);
			rx_frame_reference <= 1'($urandom);
			wr(7'h00, v);
			chk("type", 16'(t), 16'(phy));
			chk("columns", (v[15] && t == 6) ? 16'h0054 : 16'h0056, 16'(cols));
			chk("cell len", v[7] ? 16'h0035 : 16'h0039, 16'(clen));
			chk("modes", 16'({v[9], v[7:3]}), 16'({scr, hec, par, ext, cod, unf}));
			pv = (v[11] && !v[7] && (t == 2 || t == 3)) ? ext_8k_reference : rx_frame_reference;
			chk("frame sync", 16'(pv), 16'(tfs));
			rd(7'h00, d);
			chk("readback", v, d);
		end
		wr(7'h01, ~v);
		rd(7'h01, d);
		chk("unmapped", 16'h0000, d);
		rd(7'h00, d);
		chk("unmapped write", v, d);
		srst <= 1'b1;
		repeat (2) @(posedge clock);
		srst <= 1'b0;
		rd(7'h00, d);
		chk("kept", v, d);
		foreach (pcfg[k]) begin
			c = pcfg[k];
			wr(7'h00, c);
			for (int i = 0; i < 24; i++) begin
				@(posedge clock);
				tx_line_data <= 8'($urandom);
				receive_hold_input <= 1'($urandom);
				loss_of_cell_delineation <= 1'($urandom);
				#1;
				if (i > 0) begin
					chk("rx feed", 16'(ef), 16'(rx_feed));
					chk("valid", 16'(pv), 16'(payload_valid));
					chk("gating", 16'(eg), 16'({cell_accept, fifo_out_enable}));
				end
				if (c[14] && !c[6])
					ef = {tx_line_data, transmit_sync_input};
				else
					ef = {rx_line_data, rx_line_sync};
				pv = c[3] | !ef.sync;
				eg[0] = !(c[10] && receive_hold_input);
				eg[1] = eg[0] && (c[8] || !loss_of_cell_delineation);
			end
		end
		wr(7'h00, 16'h1002);
		sa = 16'($urandom) | 16'h0001;
		sb = 16'($urandom) | 16'h0002;
		sc = 16'($urandom) | 16'h0004;
		@(posedge clock);
		line_status_live <= sa;
		counter_status_live <= sc;
		@(posedge clock);
		line_status_live <= 16'h0000;
		counter_status_live <= 16'h0000;
		one_second_reference_input <= 1'b1;
		repeat (6) @(posedge clock);
		one_second_reference_input <= 1'b0;
		srd(1'b0, d);
		chk("latched", sa, d);
		line_status_live <= sb;
		srd(1'b0, d);
		chk("second read", sb, d);
		line_status_live <= 16'h0000;
		srd(1'b0, d);
		chk("cleared", 16'h0000, d);
		srd(1'b1, d);
		chk("held", sc, d);
		srd(1'b1, d);
		chk("reloaded", 16'h0000, d);
		wr(7'h00, 16'h2002);
		@(posedge clock);
		counter_status_live <= sc;
		@(posedge clock);
		counter_status_live <= 16'h0000;
		one_second_reference_input <= 1'b1;
		repeat (6) @(posedge clock);
		one_second_reference_input <= 1'b0;
		srd(1'b1, d);
		chk("count latched", sc, d);
		srd(1'b1, d);
		chk("count current", 16'h0000, d);
		report_and_stop();
	end

	initial begin
		#20000;
		fail_count++;
		report_and_stop();
	end
endmodule : tb
`default_nettype wire
